// ===== src/dual_slope_pwm_timer16.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "dual_slope_pwm_defines.svh"

module dual_slope_pwm_timer16
   import dual_slope_pwm_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic [2:0]       regAddr,
   input  wire logic [15:0]      regWriteData,
   input  wire logic             regWrite,
   input  wire logic             regRead,
   output logic      [15:0]      regReadData,
   input  wire logic [1:0]       portData,
   output logic      [1:0]       pinOut,
   output logic      [1:0]       pinOe,
   output logic                  channelAWaveOutput,
   output logic                  channelBWaveOutput,
   output logic                  overflowFlag,
   output logic                  compareAFlag,
   output logic                  compareBFlag,
   output logic                  captureFlag,
   output logic      [CNT_W-1:0] counterValue
);

   if (CNT_W < 10 || CNT_W > 16) begin : g_width_check
      $error("CNT_W must lie between 10 and 16");
   end

   timer_ctrl_t                ctrl_r;
   logic [1:0][CNT_W-1:0]      cmpBuffer_r;
   logic [1:0][CNT_W-1:0]      cmpActive_r;
   logic [CNT_W-1:0]           captureTop_r;
   logic [CNT_W-1:0]           count_r;
   count_dir_t                 dir_r;
   logic [3:0]                 flags_r;

   logic                       timerTick;
   logic                       isPhaseCorrect;
   logic                       isFreqCorrect;
   logic                       isDualSlope;
   logic                       topFromCapture;
   logic                       topFromCmpA;
   logic                       toggleModeOk;
   logic [CNT_W-1:0]           topValue;
   logic [CNT_W-1:0]           writeMask;
   logic                       atTop;
   logic                       atBottom;
   logic                       reloadNow;
   logic [1:0]                 match;
   logic [1:0]                 waveOut;
   logic [1:0][1:0]            chanConfig;
   slope_event_t               slope;
   logic [3:0]                 flagSet;
   logic [3:0]                 flagClear;
   logic [15:0]                readMux;

   timer_prescaler u_prescaler (
      .core_clk    (core_clk),
      .srst        (srst),
      .clockSelect (ctrl_r.clockSelect),
      .timerTick   (timerTick)
   );

   // mode decode
   always_comb begin
      isPhaseCorrect = 1'b0;
      isFreqCorrect  = 1'b0;
      topFromCapture = 1'b0;
      topFromCmpA    = 1'b0;
      topValue       = {CNT_W{1'b1}};
      writeMask      = {CNT_W{1'b1}};
      case (ctrl_r.waveformModeSelect)
         `MODE_PC_8BIT: begin
            isPhaseCorrect = 1'b1;
            topValue       = CNT_W'(`TOP_8BIT);
            writeMask      = CNT_W'(`TOP_8BIT);
         end
         `MODE_PC_9BIT: begin
            isPhaseCorrect = 1'b1;
            topValue       = CNT_W'(`TOP_9BIT);
            writeMask      = CNT_W'(`TOP_9BIT);
         end
         `MODE_PC_10BIT: begin
            isPhaseCorrect = 1'b1;
            topValue       = CNT_W'(`TOP_10BIT);
            writeMask      = CNT_W'(`TOP_10BIT);
         end
         `MODE_PC_CAP: begin
            isPhaseCorrect = 1'b1;
            topFromCapture = 1'b1;
            topValue       = captureTop_r;
         end
         `MODE_PC_CMPA: begin
            isPhaseCorrect = 1'b1;
            topFromCmpA    = 1'b1;
            topValue       = cmpActive_r[0];
         end
         `MODE_PFC_CAP: begin
            isFreqCorrect  = 1'b1;
            topFromCapture = 1'b1;
            topValue       = captureTop_r;
         end
         `MODE_PFC_CMPA: begin
            isFreqCorrect  = 1'b1;
            topFromCmpA    = 1'b1;
            topValue       = cmpActive_r[0];
         end
         default: begin
            isPhaseCorrect = 1'b0;
         end
      endcase
   end

   assign isDualSlope  = isPhaseCorrect || isFreqCorrect;
   assign toggleModeOk = (ctrl_r.waveformModeSelect >= `MODE_PFC_CAP) &&
                         (ctrl_r.waveformModeSelect <= `MODE_PC_CMPA);
   assign atTop        = (count_r == topValue);
   assign atBottom     = (count_r == '0);

   assign slope.tick       = timerTick && isDualSlope;
   assign slope.atTop      = atTop;
   assign slope.atBottom   = atBottom;
   assign slope.countingUp = atBottom || (!atTop && dir_r == DIR_UP);

   // control register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_r <= `CTRL_RESET;
      end else if (regWrite && regAddr == `ADDR_CTRL) begin
         ctrl_r <= regWriteData[12:0];
      end
   end

   // capture register as TOP is not buffered: a low value written while
   // counting past it lets the counter run to all ones and wrap
   always_ff @(posedge core_clk) begin
      if (srst) begin
         captureTop_r <= '0;
      end else if (regWrite && regAddr == `ADDR_CAPTURE_TOP) begin
         captureTop_r <= regWriteData[CNT_W-1:0];
      end
   end

   // dual-slope counter
   always_ff @(posedge core_clk) begin
      if (srst) begin
         count_r <= '0;
         dir_r   <= DIR_UP;
      end else if (regWrite && regAddr == `ADDR_COUNTER) begin
         count_r <= regWriteData[CNT_W-1:0];
      end else if (slope.tick) begin
         if (dir_r == DIR_UP) begin
            if (atTop) begin
               count_r <= count_r - CNT_W'(1);
               dir_r   <= DIR_DOWN;
            end else begin
               count_r <= count_r + CNT_W'(1);
            end
         end else begin
            if (atBottom) begin
               count_r <= count_r + CNT_W'(1);
               dir_r   <= DIR_UP;
            end else begin
               count_r <= count_r - CNT_W'(1);
            end
         end
      end
   end

   // outside the dual-slope modes the compare values follow at once
   assign reloadNow = !isDualSlope ||
                      (slope.tick && isPhaseCorrect && atTop) ||
                      (slope.tick && isFreqCorrect && atBottom);

   assign chanConfig[0] = ctrl_r.channelAOutputConfig;
   assign chanConfig[1] = ctrl_r.channelBOutputConfig;

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      localparam logic [2:0] CMP_ADDR = (ch == 0) ? `ADDR_CMP_A
                                                  : `ADDR_CMP_B;

      always_ff @(posedge core_clk) begin
         if (srst) begin
            cmpBuffer_r[ch] <= '0;
         end else if (regWrite && regAddr == CMP_ADDR) begin
            cmpBuffer_r[ch] <= regWriteData[CNT_W-1:0] &
                               writeMask;
         end
      end

      always_ff @(posedge core_clk) begin
         if (srst) begin
            cmpActive_r[ch] <= '0;
         end else if (reloadNow) begin
            cmpActive_r[ch] <= cmpBuffer_r[ch];
         end
      end

      assign match[ch] = (count_r == cmpActive_r[ch]);

      pwm_channel_unit u_chan (
         .core_clk            (core_clk),
         .srst                (srst),
         .slope               (slope),
         .compareMatch        (match[ch]),
         .channelOutputConfig (chanConfig[ch]),
         .toggleAllowed       ((ch == 0) && toggleModeOk),
         .pinDirectionBit     (ctrl_r.pinDirectionBit[ch]),
         .portData            (portData[ch]),
         .channelWaveOutput   (waveOut[ch]),
         .pinOut              (pinOut[ch]),
         .pinOe               (pinOe[ch])
      );
   end

   assign channelAWaveOutput = waveOut[0];
   assign channelBWaveOutput = waveOut[1];

   // flag events; a set in the cycle of a clear wins
   assign flagSet[`FLG_OVERFLOW] = slope.tick && atBottom;
   assign flagSet[`FLG_CMP_A]    = slope.tick &&
                                   (match[0] ||
                                    (atTop && topFromCmpA));
   assign flagSet[`FLG_CMP_B]    = slope.tick && match[1];
   assign flagSet[`FLG_CAPTURE]  = slope.tick && atTop &&
                                   topFromCapture;
   assign flagClear = (regWrite && regAddr == `ADDR_FLAGS) ?
                      regWriteData[3:0] : 4'h0;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         flags_r <= `FLAGS_RESET;
      end else begin
         flags_r <= (flags_r & ~flagClear) | flagSet;
      end
   end

   assign overflowFlag = flags_r[`FLG_OVERFLOW];
   assign compareAFlag = flags_r[`FLG_CMP_A];
   assign compareBFlag = flags_r[`FLG_CMP_B];
   assign captureFlag  = flags_r[`FLG_CAPTURE];
   assign counterValue = count_r;

   // register read: compare locations show the buffered value
   always_comb begin
      readMux = 16'h0000;
      case (regAddr)
         `ADDR_CTRL:        readMux = {3'h0, ctrl_r};
         `ADDR_CMP_A:       readMux = 16'(cmpBuffer_r[0]);
         `ADDR_CMP_B:       readMux = 16'(cmpBuffer_r[1]);
         `ADDR_CAPTURE_TOP: readMux = 16'(captureTop_r);
         `ADDR_COUNTER:     readMux = 16'(count_r);
         `ADDR_FLAGS:       readMux = {12'h000, flags_r};
         default:           readMux = 16'h0000;
      endcase
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge core_clk) begin
      if (srst) begin
         regReadData <= 16'h0000;
      end else if (regRead) begin
         regReadData <= readMux;
      end else begin
         regReadData <= 16'h0000;
      end
   end

endmodule : dual_slope_pwm_timer16

// ===== src/dual_slope_pwm_defines.svh
`ifndef DUAL_SLOPE_PWM_DEFINES_SVH
`define DUAL_SLOPE_PWM_DEFINES_SVH

// register word offsets on the plain register port
`define ADDR_CTRL        3'h0
`define ADDR_CMP_A       3'h1
`define ADDR_CMP_B       3'h2
`define ADDR_CAPTURE_TOP 3'h3
`define ADDR_COUNTER     3'h4
`define ADDR_FLAGS       3'h5

// reset values
`define CTRL_RESET       13'h0000
`define FLAGS_RESET      4'h0

// flag bit positions in the flag register
`define FLG_OVERFLOW     0
`define FLG_CMP_A        1
`define FLG_CMP_B        2
`define FLG_CAPTURE      3

// waveform mode codes
`define MODE_PC_8BIT     4'h1
`define MODE_PC_9BIT     4'h2
`define MODE_PC_10BIT    4'h3
`define MODE_PFC_CAP     4'h8
`define MODE_PFC_CMPA    4'h9
`define MODE_PC_CAP      4'ha
`define MODE_PC_CMPA     4'hb

// fixed TOP values
`define TOP_8BIT         16'h00ff
`define TOP_9BIT         16'h01ff
`define TOP_10BIT        16'h03ff

// channel output configurations
`define CFG_OFF          2'h0
`define CFG_TOGGLE       2'h1
`define CFG_NONINV       2'h2
`define CFG_INV          2'h3

// prescaler selects and terminal counts (divide by N: count N-1)
`define CLKSEL_STOP      3'h0
`define CLKSEL_DIV1      3'h1
`define CLKSEL_DIV8      3'h2
`define CLKSEL_DIV64     3'h3
`define CLKSEL_DIV256    3'h4
`define CLKSEL_DIV1024   3'h5
`define TERM_DIV1        10'h000
`define TERM_DIV8        10'h007
`define TERM_DIV64       10'h03f
`define TERM_DIV256      10'h0ff
`define TERM_DIV1024     10'h3ff

`endif

// ===== src/dual_slope_pwm_pkg.sv
package dual_slope_pwm_pkg;

   typedef enum logic {
      DIR_UP,
      DIR_DOWN
   } count_dir_t;

   typedef struct packed {
      logic [1:0] pinDirectionBit;
      logic [2:0] clockSelect;
      logic [1:0] channelBOutputConfig;
      logic [1:0] channelAOutputConfig;
      logic [3:0] waveformModeSelect;
   } timer_ctrl_t;

   // what a compare channel needs to know about the slope this cycle
   typedef struct packed {
      logic tick;
      logic atTop;
      logic atBottom;
      logic countingUp;
   } slope_event_t;

endpackage : dual_slope_pwm_pkg

// ===== src/timer_prescaler.sv
`timescale 1ns/1ps
`include "dual_slope_pwm_defines.svh"

module timer_prescaler (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic [2:0] clockSelect,
   output logic            timerTick
);

   logic [9:0] div_r;
   logic [9:0] term;
   logic       run;

   always_comb begin
      run  = 1'b1;
      term = `TERM_DIV1;
      case (clockSelect)
         `CLKSEL_DIV1:    term = `TERM_DIV1;
         `CLKSEL_DIV8:    term = `TERM_DIV8;
         `CLKSEL_DIV64:   term = `TERM_DIV64;
         `CLKSEL_DIV256:  term = `TERM_DIV256;
         `CLKSEL_DIV1024: term = `TERM_DIV1024;
         default:         run  = 1'b0;
      endcase
   end

   assign timerTick = run && (div_r == term);

   always_ff @(posedge core_clk) begin
      if (srst || !run || timerTick) begin
         div_r <= 10'h000;
      end else begin
         div_r <= div_r + 10'h001;
      end
   end

endmodule : timer_prescaler

// ===== src/pwm_channel_unit.sv
`timescale 1ns/1ps
`include "dual_slope_pwm_defines.svh"

module pwm_channel_unit
   import dual_slope_pwm_pkg::*;
(
   input  wire logic         core_clk,
   input  wire logic         srst,
   input  wire slope_event_t slope,
   input  wire logic         compareMatch,
   input  wire logic [1:0]   channelOutputConfig,
   input  wire logic         toggleAllowed,
   input  wire logic         pinDirectionBit,
   input  wire logic         portData,
   output logic              channelWaveOutput,
   output logic              pinOut,
   output logic              pinOe
);

   logic wave_r;
   logic connected;
   logic hit;

   // toggle only on channels and modes that allow it; else disconnected
   assign connected = (channelOutputConfig == `CFG_NONINV) ||
                      (channelOutputConfig == `CFG_INV) ||
                      ((channelOutputConfig == `CFG_TOGGLE) &&
                       toggleAllowed);
   assign hit = slope.tick && compareMatch;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         wave_r <= 1'b0;
      end else if (hit) begin
         // countingUp is forced low at TOP and high at BOTTOM so that
         // compare = TOP and compare = 0 give a steady level
         case (channelOutputConfig)
            `CFG_NONINV: wave_r <= !slope.countingUp;
            `CFG_INV:    wave_r <= slope.countingUp;
            `CFG_TOGGLE: wave_r <= wave_r ^ toggleAllowed;
            default:     wave_r <= wave_r;
         endcase
      end
   end

   assign channelWaveOutput = wave_r;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pinOut <= 1'b0;
         pinOe  <= 1'b0;
      end else begin
         pinOe  <= pinDirectionBit;
         pinOut <= (connected && pinDirectionBit) ? wave_r : portData;
      end
   end

endmodule : pwm_channel_unit

// ===== tb/pwm_power_stage.sv
`timescale 1ns/1ps

module pwm_power_stage (
   input  wire logic [1:0] pinOut,
   input  wire logic [1:0] pinOe,
   output logic      [1:0] gateLevel
);
   // gate inputs carry pull-downs, so a pin left undriven reads low
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         gateLevel[i] = pinOe[i] ? pinOut[i] : 1'b0;
      end
   end
endmodule : pwm_power_stage

// ===== tb/dual_slope_pwm_timer16_monitor.sv
`timescale 1ns/1ps
`include "dual_slope_pwm_defines.svh"

module dual_slope_pwm_timer16_monitor
   import dual_slope_pwm_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic             core_clk,
   input wire logic             srst,
   input wire logic [2:0]       regAddr,
   input wire logic [15:0]      regWriteData,
   input wire logic             regWrite,
   input wire logic             regRead,
   input wire logic [15:0]      regReadData,
   input wire logic [1:0]       portData,
   input wire logic [1:0]       pinOut,
   input wire logic [1:0]       pinOe,
   input wire logic             channelAWaveOutput,
   input wire logic             overflowFlag,
   input wire logic             captureFlag,
   input wire logic [CNT_W-1:0] counterValue
);
   timer_ctrl_t ctrlShadow_r;
   logic [15:0] capShadow_r;
   logic        fullSpeed;
   logic        stopped;
   logic        portOnlyB;

   // register mirrors rebuilt from bus traffic only
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrlShadow_r <= '0;
      end else if (regWrite && regAddr == `ADDR_CTRL) begin
         ctrlShadow_r <= timer_ctrl_t'(regWriteData[12:0]);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         capShadow_r <= '0;
      end else if (regWrite && regAddr == `ADDR_CAPTURE_TOP) begin
         capShadow_r <= regWriteData;
      end
   end

   assign fullSpeed = ctrlShadow_r.clockSelect == `CLKSEL_DIV1 && !regWrite
      && ctrlShadow_r.waveformModeSelect inside {[4'h1:4'h3], [4'h8:4'hb]};
   assign stopped = ctrlShadow_r.clockSelect == `CLKSEL_STOP && !regWrite;
   assign portOnlyB = !ctrlShadow_r.pinDirectionBit[1]
      || ctrlShadow_r.channelBOutputConfig inside {`CFG_OFF, `CFG_TOGGLE};

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence fallToZero_s;
      fullSpeed && counterValue == CNT_W'(1)
      ##1 fullSpeed && counterValue == '0;
   endsequence

   sequence riseToTop8_s;
      fullSpeed && ctrlShadow_r.waveformModeSelect == `MODE_PC_8BIT
      && counterValue == CNT_W'(16'h00fe)
      ##1 fullSpeed && counterValue == CNT_W'(`TOP_8BIT);
   endsequence

   readIdle_a: assert property (!$past(regRead) |-> regReadData == '0)
      else $error("read data present outside its slot");
   dirFollow_a: assert property (
      pinOe == $past(ctrlShadow_r.pinDirectionBit))
      else $error("pin enable differs from direction bits");
   pinBPort_a: assert property (
      !$past(srst) && $past(portOnlyB) |-> pinOut[1] == $past(portData[1]))
      else $error("channel B pin not carrying port data");
   pinAWave_a: assert property (
      !$past(srst) && $past(ctrlShadow_r.pinDirectionBit[0]
      && ctrlShadow_r.channelAOutputConfig[1])
      |-> pinOut[0] == $past(channelAWaveOutput))
      else $error("channel A pin not carrying waveform");
   stopHold_a: assert property (
      !$past(srst) && $past(stopped) && $past(stopped, 2)
      |-> $stable(counterValue))
      else $error("counter moved with clock stopped");
   overflowZero_a: assert property (
      $rose(overflowFlag) |-> $past(counterValue) == '0)
      else $error("overflow flag set away from zero");
   captureTop_a: assert property (
      $rose(captureFlag) |-> $past(counterValue) == $past(capShadow_r))
      else $error("capture flag set away from capture top");
   bottomTurn_a: assert property (
      fallToZero_s |=> counterValue == CNT_W'(1))
      else $error("counter did not turn up at zero");
   topTurn_a: assert property (
      riseToTop8_s |=> counterValue == CNT_W'(16'h00fe))
      else $error("counter did not turn down at top");
endmodule : dual_slope_pwm_timer16_monitor

bind dual_slope_pwm_timer16 dual_slope_pwm_timer16_monitor #(
   .CNT_W(CNT_W)
) u_monitor (
   .core_clk(core_clk), .srst(srst), .regAddr(regAddr),
   .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
   .regReadData(regReadData), .portData(portData), .pinOut(pinOut),
   .pinOe(pinOe), .channelAWaveOutput(channelAWaveOutput),
   .overflowFlag(overflowFlag), .captureFlag(captureFlag),
   .counterValue(counterValue)
);

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "dual_slope_pwm_defines.svh"

module testbench;
   import dual_slope_pwm_pkg::*;

   typedef struct {
      logic [3:0]  mode;
      logic [15:0] top;
      logic [15:0] cmpA;
      logic [15:0] cmpB;
      logic [15:0] cmpB2;
      logic [1:0]  cfgA;
      logic [1:0]  cfgB;
   } row_t;

   localparam int N_ROWS = 7;
   // TOP never moves mid-run and stays at or above every compare
   row_t rows [N_ROWS] = '{
      '{`MODE_PC_8BIT, 16'h00ff, 16'h0002, 16'h0080, 16'h0040, 2'h2, 2'h3},
      '{`MODE_PC_9BIT, 16'h01ff, 16'h0000, 16'h01ff, 16'h0100, 2'h2, 2'h3},
      '{`MODE_PC_10BIT, 16'h03ff, 16'h03ff, 16'h0000, 16'h0010, 2'h2, 2'h3},
      '{`MODE_PC_CAP, 16'h0003, 16'h0001, 16'h0002, 16'h0001, 2'h3, 2'h2},
      '{`MODE_PC_CMPA, 16'h0010, 16'h0010, 16'h0005, 16'h000a, 2'h1, 2'h2},
      '{`MODE_PFC_CAP, 16'h0020, 16'h0007, 16'h0020, 16'h0011, 2'h2, 2'h1},
      '{`MODE_PFC_CMPA, 16'h000c, 16'h000c, 16'h0004, 16'h0009, 2'h1, 2'h3}
   };
   logic [15:0] masks [3] = '{`TOP_8BIT, `TOP_9BIT, `TOP_10BIT};
   int          divs [5] = '{1, 8, 64, 256, 1024};

   logic        core_clk = 1'b0;
   logic        srst;
   logic [2:0]  regAddr;
   logic [15:0] regWriteData;
   logic        regWrite;
   logic        regRead;
   logic [15:0] regReadData;
   logic [1:0]  portData;
   logic [1:0]  pinOut;
   logic [1:0]  pinOe;
   logic [1:0]  gateLevel;
   logic        channelAWaveOutput;
   logic        channelBWaveOutput;
   logic        overflowFlag;
   logic        compareAFlag;
   logic        compareBFlag;
   logic        captureFlag;
   logic [15:0] counterValue;
   logic [15:0] rd;
   logic [15:0] cnt, top, actA, actB, bufB;
   logic        up, wA, wB;
   logic [3:0]  flags;
   int          n_fail = 0;
   int          n_compared = 0;
   int          n;

   always #20 core_clk = ~core_clk;

   dual_slope_pwm_timer16 #(.CNT_W(16)) i_dut (
      .core_clk(core_clk), .srst(srst), .regAddr(regAddr),
      .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
      .regReadData(regReadData), .portData(portData), .pinOut(pinOut),
      .pinOe(pinOe), .channelAWaveOutput(channelAWaveOutput),
      .channelBWaveOutput(channelBWaveOutput), .overflowFlag(overflowFlag),
      .compareAFlag(compareAFlag), .compareBFlag(compareBFlag),
      .captureFlag(captureFlag), .counterValue(counterValue)
   );

   pwm_power_stage u_stage (
      .pinOut(pinOut), .pinOe(pinOe), .gateLevel(gateLevel)
   );

   task automatic compare_word(logic [15:0] got, logic [15:0] exp,
                               string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
                  exp);
      end
   endtask : compare_word

   task automatic compare_bit(logic got, logic exp, string what);
      compare_word({15'h0, got}, {15'h0, exp}, what);
   endtask : compare_bit

   task automatic write_reg(logic [2:0] a, logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWriteData <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask : write_reg

   task automatic read_reg(logic [2:0] a, output logic [15:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1;
      d = regReadData;
   endtask : read_reg

   task automatic apply_reset;
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
   endtask : apply_reset

   task automatic wait_change(output int k);
      logic [15:0] old;
      old = counterValue;
      k = 0;
      do begin
         @(posedge core_clk);
         #1;
         k++;
      end while (counterValue === old && k < 2100);
   endtask : wait_change

   function automatic logic next_wave(logic [1:0] cfg, logic mUp, logic cur,
                                      logic ok);
      if (cfg == `CFG_OFF) return cur;
      if (cfg == `CFG_TOGGLE) return ok ? !cur : cur;
      return (cfg == `CFG_INV) ? mUp : !mUp;
   endfunction : next_wave

   // one timer tick of the reference counter, matches and reloads
   task automatic model_step(row_t rw);
      logic mUp;
      mUp = (cnt == 16'h0) || (up && cnt != top);
      if (cnt == 16'h0) flags[`FLG_OVERFLOW] = 1'b1;
      if (cnt == actA) begin
         flags[`FLG_CMP_A] = 1'b1;
         wA = next_wave(rw.cfgA, mUp, wA, rw.mode inside {[4'h8:4'hb]});
      end
      if (cnt == actB) begin
         flags[`FLG_CMP_B] = 1'b1;
         wB = next_wave(rw.cfgB, mUp, wB, 1'b0);
      end
      if (cnt == top && rw.mode inside {`MODE_PC_CAP, `MODE_PFC_CAP}) begin
         flags[`FLG_CAPTURE] = 1'b1;
      end
      if (cnt == (rw.mode inside {4'h8, 4'h9} ? 16'h0 : top)) actB = bufB;
      if (up) begin
         up = (cnt != top);
         cnt = up ? cnt + 16'h1 : cnt - 16'h1;
      end else begin
         up = (cnt == 16'h0);
         cnt = up ? cnt + 16'h1 : cnt - 16'h1;
      end
   endtask : model_step

   task automatic run_row(row_t rw);
      write_reg(`ADDR_CAPTURE_TOP, rw.top);
      write_reg(`ADDR_CMP_A, rw.cmpA);
      write_reg(`ADDR_CMP_B, rw.cmpB);
      write_reg(`ADDR_CTRL, {3'h0, 2'b11, `CLKSEL_DIV1, rw.cfgB, rw.cfgA,
                             rw.mode});
      {cnt, up, top, actA, actB, bufB} = {16'h0, 1'b1, rw.top, rw.cmpA,
                                          rw.cmpB, rw.cmpB};
      {wA, wB, flags} = '0;
      n = 0;
      #1;
      while (counterValue === 16'h0 && n < 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      for (int i = 0; i < 3 * int'(rw.top) + 4; i++) begin
         model_step(rw);
         // the new B compare lands in the buffer at the third tick edge
         if (i == 2) bufB = rw.cmpB2;
         if (i > 0) begin
            @(posedge core_clk);
            regWrite <= (i == 1);
            regAddr <= `ADDR_CMP_B;
            regWriteData <= rw.cmpB2;
            #1;
         end
         compare_word(counterValue, cnt, "counter");
         compare_word({12'h0, captureFlag, compareBFlag, compareAFlag,
                       overflowFlag},
                      {12'h0, flags}, "flags");
         compare_bit(channelAWaveOutput, wA, "wave A");
         compare_bit(channelBWaveOutput, wB, "wave B");
      end
   endtask : run_row

   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (40000) @(posedge core_clk);
      n_fail++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      {srst, regAddr, regWriteData, regWrite, regRead, portData} = '0;
      srst = 1'b1;
      apply_reset();
      for (int a = 0; a < 8; a++) begin
         read_reg(3'(a), rd);
         compare_word(rd, 16'h0000, "reset read");
      end
      for (int r = 0; r < N_ROWS; r++) begin
         run_row(rows[r]);
         apply_reset();
      end
      // fixed top trims compare writes by the mode in force at write time
      for (int m = 1; m <= 3; m++) begin
         write_reg(`ADDR_CTRL, {12'h0, 4'(m)});
         write_reg(`ADDR_CMP_B, 16'hffff);
         read_reg(`ADDR_CMP_B, rd);
         compare_word(rd, masks[m-1], "masked compare");
      end
      for (int s = 0; s < 5; s++) begin
         apply_reset();
         write_reg(`ADDR_CTRL, {5'h0, 3'(s + 1), 4'h0, `MODE_PC_8BIT});
         wait_change(n);
         wait_change(n);
         compare_word(16'(n), 16'(divs[s]), "tick spacing");
      end
      write_reg(`ADDR_CTRL, {3'h0, 2'b01, `CLKSEL_STOP, `CFG_NONINV, `CFG_OFF,
                             `MODE_PC_8BIT});
      portData <= 2'b11;
      repeat (2) @(posedge core_clk);
      #1;
      compare_bit(gateLevel[0], 1'b1, "pin A port data");
      compare_bit(gateLevel[1], 1'b0, "pin B undriven");
      // ticks at 0 and 1 passed; the one at zero set overflow plus both zero compares
      read_reg(`ADDR_FLAGS, rd);
      compare_word(rd, 16'h0007, "flags at zero");
      write_reg(`ADDR_FLAGS, 16'h0005);
      read_reg(`ADDR_FLAGS, rd);
      compare_word(rd, 16'h0002, "flags cleared");
      tally_and_finish();
   end
endmodule : testbench
